// ==== rtl/pushbutton_operand_logic_regs.vh ====
// Register map, field positions, reset values and timing counts for the pushbutton operand logic.
`ifndef PUSHBUTTON_OPERAND_LOGIC_REGS_VH
`define PUSHBUTTON_OPERAND_LOGIC_REGS_VH

`define CTRL_OFFSET       14'h0000
`define MODE_OFFSET       14'h0004
`define STATUS_OFFSET     14'h0008
`define IRQ_STAT_OFFSET   14'h000c
`define IRQ_MASK_OFFSET   14'h0010
`define EVENT_OFFSET      14'h0014
`define HOLD_BASE_PAGE    8'h01
`define TEXT_REGION_BIT   13

`define CTRL_LOG_EN_BIT   0
`define CTRL_BRK_KEYS_BIT 1
`define CTRL_RESET        2'h0
`define MODE_RESET        24'h000000
`define HOLD_RESET        16'h0000
`define IRQ_MASK_RESET    2'h0

`define STATUS_CTRL_LSB   0
`define STATUS_USER_LSB   8
`define IRQ_PRESS_BIT     0
`define IRQ_MSG_BIT       1

`define MODE_DISABLED     2'h0
`define MODE_MOMENTARY    2'h1
`define MODE_TOGGLE       2'h2

`define LINE_TITLE        2'h0
`define LINE_ON           2'h1
`define LINE_OFF          2'h2

`define CLK_PERIOD_PS     4000
`define TICK_PERIOD_MS    1
`define TICK_CYCLES       ((`TICK_PERIOD_MS * 1000000000) / `CLK_PERIOD_PS)
`define HOLDOFF_MS        100

`endif

// ==== rtl/key_text_memory.v ====
// Message text store, one character per word, with a registered read port.
`timescale 1ns/10ps
`default_nettype none
module key_text_memory #(
   parameter ADDR_W = 11,
   parameter DATA_W = 8
) (
   input  wire              clock_in,
   input  wire              rst_b_in,
   input  wire              wr_en_in,
   input  wire [ADDR_W-1:0] wr_addr_in,
   input  wire [DATA_W-1:0] wr_data_in,
   input  wire [ADDR_W-1:0] rd_addr_in,
   output reg  [DATA_W-1:0] rd_data_out
);
   reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // The array itself has no reset so it can map onto block memory.
   always @(posedge clock_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_data_out <= {DATA_W{1'b0}};
      end else begin
         rd_data_out <= mem[rd_addr_in];
      end
   end
endmodule // key_text_memory
`default_nettype wire

// ==== rtl/pushbutton_operand_logic.v ====
// Faceplate control and user key operand logic with an Avalon-MM register slave.
`timescale 1ns/10ps
`default_nettype none
`include "pushbutton_operand_logic_regs.vh"
module pushbutton_operand_logic #(
   parameter N_CTRL      = 7,
   parameter N_USER      = 12,
   parameter TICK_CYCLES = `TICK_CYCLES,
   parameter HOLDOFF_MS  = `HOLDOFF_MS
) (
   input  wire               clock_in,
   input  wire               rst_b_in,
   input  wire [13:0]        address_in,
   input  wire               read_in,
   input  wire               write_in,
   input  wire [31:0]        writedata_in,
   input  wire [3:0]         byteenable_in,
   output reg  [31:0]        readdata_out,
   output reg                waitrequest_out,
   input  wire [N_CTRL-1:0]  ctrl_key_in,
   input  wire [N_USER-1:0]  user_key_in,
   input  wire [N_USER-1:0]  nv_restore_in,
   output reg  [N_CTRL-1:0]  control_key_active_out,
   output reg                ctrl_event_out,
   output reg  [N_USER-1:0]  user_on_out,
   output reg  [N_USER-1:0]  user_off_out,
   output reg  [N_USER-1:0]  user_led_out,
   output reg  [N_USER-1:0]  nv_state_out,
   output reg                msg_valid_out,
   output reg  [3:0]         msg_key_out,
   output reg                msg_off_out,
   input  wire [4:0]         disp_char_idx_in,
   input  wire               disp_body_in,
   output wire [7:0]         disp_char_out,
   output reg                irq_out
);
   localparam NK = N_CTRL + N_USER;

   function [31:0] be_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  be;
      integer b;
      begin
         be_merge = old_v;
         for (b = 0; b < 4; b = b + 1) begin
            if (be[b]) begin
               be_merge[b*8 +: 8] = new_v[b*8 +: 8];
            end
         end
      end
   endfunction

   // Keeps only the lowest set bit, so simultaneous presses resolve to one key.
   function [NK-1:0] lowest_bit;
      input [NK-1:0] v;
      begin
         lowest_bit = v & (~v + {{(NK-1){1'b0}}, 1'b1});
      end
   endfunction

   // Bus slave: one wait cycle, then the access completes.
   reg         wait_ff;
   reg  [1:0]  ctrl_ff;
   reg  [23:0] mode_ff;
   reg  [15:0] hold_ff [0:N_USER-1];
   reg  [1:0]  irq_stat_ff;
   reg  [1:0]  irq_mask_ff;
   reg  [2:0]  event_key_ff;
   wire        req     = read_in | write_in;
   wire        done    = req & ~wait_ff;
   wire        wr_done = done & write_in;
   wire        is_text = address_in[`TEXT_REGION_BIT];
   wire        is_hold = ~is_text && (address_in[13:6] == `HOLD_BASE_PAGE);
   wire [3:0]  hold_idx = address_in[5:2];
   wire [31:0] wr_ctrl = be_merge({30'h0, ctrl_ff}, writedata_in, byteenable_in);
   wire [31:0] wr_mode = be_merge({8'h0, mode_ff}, writedata_in, byteenable_in);
   wire [31:0] wr_mask = be_merge({30'h0, irq_mask_ff}, writedata_in, byteenable_in);
   wire [31:0] wr_w1c  = be_merge(32'h0, writedata_in, byteenable_in);
   wire [31:0] wr_hold = be_merge({16'h0, hold_ff[hold_idx]}, writedata_in, byteenable_in);

   // Millisecond tick for all timers.
   reg [31:0] tick_cnt_ff;
   reg        tick_ff;
   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tick_cnt_ff <= 32'h0;
         tick_ff     <= 1'b0;
      end else if (tick_cnt_ff == TICK_CYCLES - 1) begin
         tick_cnt_ff <= 32'h0;
         tick_ff     <= 1'b1;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 32'h1;
         tick_ff     <= 1'b0;
      end
   end

   // Key synchronisers; the first stage feeds only the second.
   reg  [NK-1:0] sync1_ff;
   reg  [NK-1:0] sync2_ff;
   reg  [NK-1:0] prev_ff;
   reg  [NK-1:0] acc_ff;
   wire [NK-1:0] rise = sync2_ff & ~prev_ff;
   wire [NK-1:0] nxt_acc = (acc_ff != {NK{1'b0}}) ? (acc_ff & sync2_ff) : lowest_bit(rise);
   wire [NK-1:0] press = nxt_acc & ~acc_ff;
   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sync1_ff <= {NK{1'b0}};
         sync2_ff <= {NK{1'b0}};
         prev_ff  <= {NK{1'b0}};
         acc_ff   <= {NK{1'b0}};
      end else begin
         sync1_ff <= {user_key_in, ctrl_key_in};
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
         acc_ff   <= nxt_acc;
      end
   end

   // Restore of the toggle states happens on the first clock after reset release.
   reg init_ff;
   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         init_ff <= 1'b1;
      end else begin
         init_ff <= 1'b0;
      end
   end

   wire [N_CTRL-1:0] nxt_ctrl_active;
   wire [N_USER-1:0] nxt_on;
   wire [N_USER-1:0] nxt_off;
   wire [N_USER-1:0] nxt_tog;
   wire [N_USER-1:0] is_tog;

   genvar g;
   generate
      for (g = 0; g < N_CTRL; g = g + 1) begin : ctrl_g
         reg [7:0] hold_cnt_ff;
         wire      held = acc_ff[g] & ~ctrl_ff[`CTRL_BRK_KEYS_BIT];
         always @(posedge clock_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
               hold_cnt_ff <= 8'h0;
            end else if (held) begin
               hold_cnt_ff <= HOLDOFF_MS[7:0];
            end else if (tick_ff && hold_cnt_ff != 8'h0) begin
               hold_cnt_ff <= hold_cnt_ff - 8'h1;
            end
         end
         assign nxt_ctrl_active[g] = held | (hold_cnt_ff != 8'h0);
      end
      for (g = 0; g < N_USER; g = g + 1) begin : user_g
         reg  [15:0] drop_cnt_ff;
         reg         tog_ff;
         wire [1:0]  mode = mode_ff[2*g +: 2];
         wire        held = acc_ff[N_CTRL + g];
         always @(posedge clock_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
               drop_cnt_ff <= 16'h0;
               tog_ff      <= 1'b0;
            end else begin
               if (init_ff) begin
                  tog_ff <= nv_restore_in[g];
               end else if (mode == `MODE_TOGGLE && press[N_CTRL + g]) begin
                  tog_ff <= ~tog_ff;
               end
               if (mode != `MODE_MOMENTARY) begin
                  drop_cnt_ff <= 16'h0;
               end else if (held) begin
                  drop_cnt_ff <= hold_ff[g];
               end else if (tick_ff && drop_cnt_ff != 16'h0) begin
                  drop_cnt_ff <= drop_cnt_ff - 16'h1;
               end
            end
         end
         assign is_tog[g]  = (mode == `MODE_TOGGLE);
         assign nxt_tog[g] = tog_ff;
         assign nxt_on[g]  = (mode == `MODE_MOMENTARY) ? (held | (drop_cnt_ff != 16'h0)) :
                             is_tog[g] ? tog_ff : 1'b0;
         // The spare mode code behaves as disabled, so both operands stay low for it.
         assign nxt_off[g] = (is_tog[g] || mode == `MODE_MOMENTARY) ? ~nxt_on[g] : 1'b0;
      end
   endgenerate

   // Message selection on On changes of user keys and Off changes of toggle keys.
   wire [N_USER-1:0] went_on  = nxt_on & ~user_on_out;
   wire [N_USER-1:0] went_off = ~nxt_on & user_on_out & is_tog;
   reg  [3:0]        on_idx;
   reg  [3:0]        off_idx;
   integer           i;
   always @* begin
      on_idx  = 4'h0;
      off_idx = 4'h0;
      for (i = N_USER - 1; i >= 0; i = i - 1) begin
         if (went_on[i]) begin
            on_idx = i[3:0];
         end
         if (went_off[i]) begin
            off_idx = i[3:0];
         end
      end
   end
   wire msg_change = (went_on != {N_USER{1'b0}}) | (went_off != {N_USER{1'b0}});

   // Logged control key press, only when logging is enabled.
   wire [N_CTRL-1:0] ctrl_press = press[N_CTRL-1:0] & {N_CTRL{~ctrl_ff[`CTRL_BRK_KEYS_BIT]}};
   wire              log_press  = ctrl_ff[`CTRL_LOG_EN_BIT] & (ctrl_press != {N_CTRL{1'b0}});
   reg  [2:0]        press_idx;
   integer           j;
   always @* begin
      press_idx = 3'h0;
      for (j = N_CTRL - 1; j >= 0; j = j - 1) begin
         if (ctrl_press[j]) begin
            press_idx = j[2:0];
         end
      end
   end

   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         control_key_active_out <= {N_CTRL{1'b0}};
         ctrl_event_out         <= 1'b0;
         user_on_out            <= {N_USER{1'b0}};
         user_off_out           <= {N_USER{1'b0}};
         user_led_out           <= {N_USER{1'b0}};
         nv_state_out           <= {N_USER{1'b0}};
         msg_valid_out          <= 1'b0;
         msg_key_out            <= 4'h0;
         msg_off_out            <= 1'b0;
         event_key_ff           <= 3'h0;
      end else begin
         control_key_active_out <= nxt_ctrl_active;
         ctrl_event_out         <= log_press;
         user_on_out            <= nxt_on;
         user_off_out           <= nxt_off;
         user_led_out           <= nxt_on;
         nv_state_out           <= nxt_tog;
         if (log_press) begin
            event_key_ff <= press_idx;
         end
         // An On change wins over an Off change in the same cycle.
         if (went_on != {N_USER{1'b0}}) begin
            msg_valid_out <= 1'b1;
            msg_key_out   <= on_idx;
            msg_off_out   <= 1'b0;
         end else if (went_off != {N_USER{1'b0}}) begin
            msg_valid_out <= 1'b1;
            msg_key_out   <= off_idx;
            msg_off_out   <= 1'b1;
         end
      end
   end

   // Title when asked for, else the on or off line of the shown key.
   wire [1:0] line_sel = !disp_body_in ? `LINE_TITLE : msg_off_out ? `LINE_OFF : `LINE_ON;

   key_text_memory #(
      .ADDR_W (11),
      .DATA_W (8)
   ) text_mem (
      .clock_in    (clock_in),
      .rst_b_in    (rst_b_in),
      .wr_en_in    (wr_done & is_text),
      .wr_addr_in  (address_in[12:2]),
      .wr_data_in  (writedata_in[7:0]),
      .rd_addr_in  ({msg_key_out, line_sel, disp_char_idx_in}),
      .rd_data_out (disp_char_out)
   );

   // Register writes, interrupt status and readback.
   integer k;
   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wait_ff      <= 1'b1;
         waitrequest_out <= 1'b1;
         readdata_out <= 32'h0;
         ctrl_ff      <= `CTRL_RESET;
         mode_ff      <= `MODE_RESET;
         irq_stat_ff  <= 2'h0;
         irq_mask_ff  <= `IRQ_MASK_RESET;
         irq_out      <= 1'b0;
         for (k = 0; k < N_USER; k = k + 1) begin
            hold_ff[k] <= `HOLD_RESET;
         end
      end else begin
         wait_ff <= ~(req & wait_ff);
         waitrequest_out <= ~(req & wait_ff);
         if (req & wait_ff) begin
            readdata_out <= 32'h0;
            if (read_in && !is_text) begin
               case (address_in)
                  `CTRL_OFFSET:     readdata_out <= {30'h0, ctrl_ff};
                  `MODE_OFFSET:     readdata_out <= {8'h0, mode_ff};
                  `STATUS_OFFSET:   readdata_out <= {12'h0, user_on_out, 1'b0,
                                                     control_key_active_out};
                  `IRQ_STAT_OFFSET: readdata_out <= {30'h0, irq_stat_ff};
                  `IRQ_MASK_OFFSET: readdata_out <= {30'h0, irq_mask_ff};
                  `EVENT_OFFSET:    readdata_out <= {29'h0, event_key_ff};
                  default: begin
                     if (is_hold && hold_idx < N_USER) begin
                        readdata_out <= {16'h0, hold_ff[hold_idx]};
                     end
                  end
               endcase
            end
         end
         if (wr_done && address_in == `CTRL_OFFSET) begin
            ctrl_ff <= wr_ctrl[1:0];
         end
         if (wr_done && address_in == `MODE_OFFSET) begin
            mode_ff <= wr_mode[23:0];
         end
         if (wr_done && address_in == `IRQ_MASK_OFFSET) begin
            irq_mask_ff <= wr_mask[1:0];
         end
         if (wr_done && is_hold && hold_idx < N_USER) begin
            hold_ff[hold_idx] <= wr_hold[15:0];
         end
         // A new event in the clearing cycle keeps its bit set.
         irq_stat_ff[`IRQ_PRESS_BIT] <= log_press |
            (irq_stat_ff[`IRQ_PRESS_BIT] &
             ~(wr_done && address_in == `IRQ_STAT_OFFSET && wr_w1c[`IRQ_PRESS_BIT]));
         irq_stat_ff[`IRQ_MSG_BIT] <= msg_change |
            (irq_stat_ff[`IRQ_MSG_BIT] &
             ~(wr_done && address_in == `IRQ_STAT_OFFSET && wr_w1c[`IRQ_MSG_BIT]));
         irq_out <= |(irq_stat_ff & irq_mask_ff);
      end
   end
endmodule // pushbutton_operand_logic
`default_nettype wire

// ==== testbench/pushbutton_operand_logic_properties.sv ====
// Port-level checks of the pushbutton operand logic.
`timescale 1ns/10ps
`default_nettype none
module pushbutton_props #(
   parameter TICK_CYCLES = 4,
   parameter HOLDOFF_MS  = 100
) (
   input wire logic        clock_in,
   input wire logic        rst_b_in,
   input wire logic        read_in,
   input wire logic        write_in,
   input wire logic        waitrequest_out,
   input wire logic [6:0]  ctrl_key_in,
   input wire logic [11:0] user_key_in,
   input wire logic [6:0]  control_key_active_out,
   input wire logic        ctrl_event_out,
   input wire logic [11:0] user_on_out,
   input wire logic [11:0] user_off_out,
   input wire logic [11:0] user_led_out
);
   localparam int MIN_REL = (HOLDOFF_MS - 1) * TICK_CYCLES;
   localparam int MAX_REL = (HOLDOFF_MS + 1) * TICK_CYCLES + 16;
   logic [31:0] rel_ff;
   // Cycles since every control key was let go; the hold-off is judged against it.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) rel_ff <= 32'h0;
      else if (|ctrl_key_in) rel_ff <= 32'h0;
      else rel_ff <= rel_ff + 32'h1;
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   sequence bus_req;
      (read_in || write_in) && waitrequest_out;
   endsequence
   bus_answer_a: assert property (bus_req |=> !waitrequest_out)
      else $error("bus request not answered");
   bus_one_wait_a: assert property (!waitrequest_out |=> waitrequest_out)
      else $error("answer held too long");
   ctrl_press_a: assert property ($rose(|control_key_active_out) |-> |$past(ctrl_key_in, 2))
      else $error("operand rose without key");
   ctrl_min_hold_a: assert property ($fell(|control_key_active_out) |-> rel_ff >= MIN_REL)
      else $error("operand dropped early");
   ctrl_max_hold_a: assert property (!(|control_key_active_out && rel_ff > MAX_REL))
      else $error("operand held too long");
   ctrl_single_a: assert property ($onehot0(control_key_active_out & ~$past(control_key_active_out)))
      else $error("two keys taken together");
   event_pulse_a: assert property (ctrl_event_out |=> !ctrl_event_out)
      else $error("event longer than one cycle");
   event_cause_a: assert property (ctrl_event_out |-> ##[0:3] |control_key_active_out)
      else $error("event without operand");
   on_off_excl_a: assert property (!(|(user_on_out & user_off_out)))
      else $error("on and off both high");
   led_follow_a: assert property (user_led_out == user_on_out)
      else $error("indicator differs from on");
endmodule // pushbutton_props
bind pushbutton_operand_logic pushbutton_props #(.TICK_CYCLES(TICK_CYCLES),
   .HOLDOFF_MS(HOLDOFF_MS)) u_props (.clock_in, .rst_b_in, .read_in, .write_in,
   .waitrequest_out, .ctrl_key_in, .user_key_in, .control_key_active_out,
   .ctrl_event_out, .user_on_out, .user_off_out, .user_led_out);
`default_nettype wire

// ==== testbench/key_operator.sv ====
// Operator model that presses and lets go faceplate keys on command.
`timescale 1ns/10ps
`default_nettype none
module key_operator (
   input  wire logic        clock_in,
   input  wire logic [6:0]  ctrl_cmd_in,
   input  wire logic [11:0] user_cmd_in,
   output var  logic [6:0]  ctrl_key_out,
   output var  logic [11:0] user_key_out
);
   initial ctrl_key_out = 7'h0;
   initial user_key_out = 12'h0;
   // A finger lands one cycle after the command; chords happen only when commanded.
   always @(posedge clock_in) begin
      ctrl_key_out <= ctrl_cmd_in;
      user_key_out <= user_cmd_in;
   end
endmodule // key_operator
`default_nettype wire

// ==== testbench/test_pushbutton_operand_logic.sv ====
// Self-checking bench of the pushbutton operand logic.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
   $display("[ERR] %0t mismatch %h exp %h", $time, a, b); end end
module test_pushbutton_operand_logic;
   localparam int TK = 4;
   logic        clock_in = 1'b0;
   logic        rst_b_in = 1'b0;
   logic        read_in = 1'b0;
   logic        write_in = 1'b0;
   logic [13:0] address_in = 14'h0;
   logic [31:0] writedata_in = 32'h0;
   logic [6:0]  ctrl_cmd = 7'h0;
   logic [11:0] user_cmd = 12'h0;
   logic [11:0] nv_restore_in;
   logic        disp_body = 1'b0;
   wire  logic [7:0]  disp_char_out;
   logic [31:0] seed = 32'h802fd33f;
   wire  logic [31:0] readdata_out;
   wire  logic waitrequest_out, ctrl_event_out, msg_valid_out, msg_off_out, irq_out;
   wire  logic [6:0]  ctrl_key_in, control_key_active_out;
   wire  logic [11:0] user_key_in, user_on_out, user_off_out, user_led_out, nv_state_out;
   wire  logic [3:0]  msg_key_out;
   int error_cnt, cmp_count, cyc, ev_n;
   int mdl_on[12];
   logic [1:0] mode[12];
   always #2 clock_in = ~clock_in;
   key_operator u_op (.clock_in, .ctrl_cmd_in(ctrl_cmd), .user_cmd_in(user_cmd),
      .ctrl_key_out(ctrl_key_in), .user_key_out(user_key_in));
   pushbutton_operand_logic #(.TICK_CYCLES(TK)) u_dut (.clock_in, .rst_b_in, .address_in,
      .read_in, .write_in, .writedata_in, .byteenable_in(4'hf), .readdata_out,
      .waitrequest_out, .ctrl_key_in, .user_key_in, .nv_restore_in, .control_key_active_out,
      .ctrl_event_out, .user_on_out, .user_off_out, .user_led_out, .nv_state_out,
      .msg_valid_out, .msg_key_out, .msg_off_out, .disp_char_idx_in(5'h0),
      .disp_body_in(disp_body), .disp_char_out, .irq_out);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic report_and_stop();
      if (error_cnt == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clock_in) begin
      if (ctrl_event_out === 1'b1) ev_n++;
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   // The request stays up until waitrequest is seen low at an edge.
   task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clock_in);
      address_in <= a;
      writedata_in <= d;
      read_in <= !wr;
      write_in <= wr;
      do @(posedge clock_in); while (waitrequest_out !== 1'b0);
      q = readdata_out;
      read_in <= 1'b0;
      write_in <= 1'b0;
   endtask
   task automatic wr(input logic [13:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [13:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      `CHK(q, e)
   endtask
   task automatic check_user();
      logic [11:0] on, en, tg;
      for (int k = 0; k < 12; k++) begin
         on[k] = mdl_on[k][0];
         en[k] = (mode[k] == 2'h1 || mode[k] == 2'h2);
         tg[k] = (mode[k] == 2'h2);
      end
      `CHK(user_on_out, on)
      `CHK(user_off_out, en & ~on)
      `CHK(user_led_out, on)
      `CHK(nv_state_out & tg, on & tg)
   endtask
   task automatic press(input int k, input int hold);
      user_cmd[k] <= 1'b1;
      repeat (hold) @(posedge clock_in);
      user_cmd[k] <= 1'b0;
      repeat (8) @(posedge clock_in);
   endtask
   initial begin
      logic [31:0] r;
      int n;
      r = rnd();
      nv_restore_in = r[11:0];
      repeat (6) @(posedge clock_in);
      rst_b_in <= 1'b1;
      rd_chk(14'h0, 32'h0);
      rd_chk(14'h4, 32'h0);
      rd_chk(14'h10, 32'h0);
      rd_chk(14'h8, 32'h0);
      wr(14'h30, 32'hffffffff);
      rd_chk(14'h30, 32'h0);
      wr(14'h4, 32'h00b055aa);
      wr(14'h10, 32'h3);
      for (int k = 0; k < 12; k++) begin
         mode[k] = 2'(32'h00b055aa >> (2 * k));
         mdl_on[k] = (mode[k] == 2'h2) ? nv_restore_in[k] : 0;
      end
      repeat (4) @(posedge clock_in);
      check_user();
      for (int i = 0; i < 24; i++) begin
         if (mode[i % 12] == 2'h2) begin
            r = rnd();
            press(i % 12, 5 + r[3:0]);
            mdl_on[i % 12] ^= 1;
            check_user();
            `CHK(msg_valid_out, 1'b1)
            `CHK(msg_key_out, 4'(i % 12))
            `CHK(msg_off_out, !mdl_on[i % 12][0])
         end
      end
      `CHK(irq_out, 1'b1)
      wr(14'hc, 32'h3);
      repeat (3) @(posedge clock_in);
      `CHK(irq_out, 1'b0)
      for (int k = 4; k < 8; k++) begin
         wr(14'h40 + 14'(4 * k), k - 4);
         user_cmd[k] <= 1'b1;
         repeat (6) @(posedge clock_in);
         mdl_on[k] = 1;
         check_user();
         user_cmd[k] <= 1'b0;
         repeat (6) @(posedge clock_in);
         mdl_on[k] = (k > 5);
         if (k != 5) check_user();
         repeat (TK * (k - 3) + 8) @(posedge clock_in);
         mdl_on[k] = 0;
         check_user();
         `CHK(msg_off_out, 1'b0)
      end
      wr(14'h2e00, 32'h41);
      wr(14'h2e80, 32'h5a);
      repeat (2) @(posedge clock_in);
      `CHK(disp_char_out, 8'h41)
      disp_body <= 1'b1;
      repeat (2) @(posedge clock_in);
      `CHK(disp_char_out, 8'h5a)
      for (int k = 8; k < 11; k++) press(k, 8);
      check_user();
      user_cmd[0] <= 1'b1;
      repeat (6) @(posedge clock_in);
      press(1, 12);
      press(0, 1);
      mdl_on[0] ^= 1;
      check_user();
      wr(14'h0, 32'h1);
      wr(14'hc, 32'h3);
      wr(14'h10, 32'h1);
      for (int k = 0; k < 7; k++) begin
         n = ev_n;
         ctrl_cmd[k] <= 1'b1;
         repeat (6) @(posedge clock_in);
         `CHK(control_key_active_out, 7'h1 << k)
         ctrl_cmd[k] <= 1'b0;
         repeat (40) @(posedge clock_in);
         `CHK(control_key_active_out, 7'h1 << k)
         `CHK(irq_out, 1'b1)
         rd_chk(14'h14, k);
         wr(14'hc, 32'h1);
         repeat (3) @(posedge clock_in);
         `CHK(irq_out, 1'b0)
         repeat (400) @(posedge clock_in);
         `CHK(control_key_active_out, 7'h0)
         `CHK(ev_n, n + 1)
      end
      wr(14'h0, 32'h3);
      n = ev_n;
      ctrl_cmd[2] <= 1'b1;
      repeat (8) @(posedge clock_in);
      `CHK(control_key_active_out, 7'h0)
      ctrl_cmd[2] <= 1'b0;
      repeat (8) @(posedge clock_in);
      wr(14'h0, 32'h0);
      ctrl_cmd[3] <= 1'b1;
      repeat (8) @(posedge clock_in);
      `CHK(control_key_active_out, 7'h8)
      ctrl_cmd[3] <= 1'b0;
      repeat (420) @(posedge clock_in);
      `CHK(ev_n, n)
      report_and_stop();
   end
endmodule // test_pushbutton_operand_logic
`default_nettype wire
